/* File: bench/btd_sampler_model.sv */
// Sampler-side partner model that collects decoded answers in arrival order
`default_nettype none

module btd_sampler_model
  import btd_pkg::*;
(
  // Clock
  input  wire logic                clock_i,
  // Answer from the decoder
  input  wire logic                texel_valid_i,
  input  wire btd_texel_t          texel_i,
  input  wire logic [OFFSET_W-1:0] block_offset_i,
  input  wire logic [OFFSET_W-1:0] image_bytes_i,
  input  wire logic                texel_outside_i
);
  timeunit 1ns;
  timeprecision 1ps;

  // Answers as {texel, offset, image bytes, outside}; the sampler never stalls
  logic [84:0] answer_q[$];

  // Take an answer at each edge where its one-cycle strobe is seen
  always @(posedge clock_i) begin
    if (texel_valid_i === 1'b1) begin
      answer_q.push_back({texel_i, block_offset_i, image_bytes_i, texel_outside_i});
    end
  end
endmodule

`default_nettype wire

/* File: bench/tb.sv */
// Self-checking testbench for the block texture decoder
`default_nettype none

`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin err_total++; \
  $display("Error at %0t: got %h expected %h", $time, (a), (b)); end end

module tb
  import btd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************************************
  // Signals and test blocks
  // ****************************************************************
  logic                clock_i;
  logic                reset_n_i;
  logic                req_valid_i;
  btd_request_t        req_i;
  logic                texel_valid_o;
  btd_texel_t          texel_o;
  logic [OFFSET_W-1:0] block_offset_o;
  logic [OFFSET_W-1:0] image_bytes_o;
  logic                texel_outside_o;
  int                  err_total;
  int                  cmp_count;
  int                  cyc_count;
  logic [84:0]         exp_q[$];
  // Codes 0,1,2,3 repeat along each row; first endpoint above or not above the second
  localparam logic [63:0] C_GT  = {32'hE4E4E4E4, 16'h07E0, 16'hF812};
  localparam logic [63:0] C_LE  = {32'hE4E4E4E4, 16'hF812, 16'h07E0};
  localparam logic [63:0] A_EXP = 64'hFEDCBA9876543210;
  localparam logic [63:0] A_INT = {48'h208208208208, 8'hC3, 8'h5A};

  btd_decoder u_btd_decoder (
    .clock_i(clock_i), .reset_n_i(reset_n_i), .req_valid_i(req_valid_i), .req_i(req_i),
    .texel_valid_o(texel_valid_o), .texel_o(texel_o), .block_offset_o(block_offset_o),
    .image_bytes_o(image_bytes_o), .texel_outside_o(texel_outside_o));

  btd_sampler_model u_btd_sampler_model (
    .clock_i(clock_i), .texel_valid_i(texel_valid_o), .texel_i(texel_o),
    .block_offset_i(block_offset_o), .image_bytes_i(image_bytes_o), .texel_outside_i(texel_outside_o));

  // Clock and cycle ceiling
  always #20 clock_i = ~clock_i;
  always @(posedge clock_i) begin
    cyc_count++;
    if (cyc_count == 3000) begin
      err_total++;
      test_done();
    end
  end

  // ****************************************************************
  // Expected answer worked out from the block layout
  // ****************************************************************
  function automatic logic [84:0] expect_ans(input btd_request_t r);
    logic [63:0] c;
    logic [7:0]  p0 [3];
    logic [7:0]  p1 [3];
    logic [7:0]  q [3];
    logic [7:0]  a;
    logic [1:0]  code;
    logic        four;
    int          s;
    int          bs;
    int          bx;
    c = r.format[1] ? r.block[127:64] : r.block[63:0];
    p0 = '{{c[15:11], c[15:13]}, {c[10:5], c[10:9]}, {c[4:0], c[4:2]}};
    p1 = '{{c[31:27], c[31:29]}, {c[26:21], c[26:25]}, {c[20:16], c[20:18]}};
    s = 4 * int'(r.texel_y[1:0]) + int'(r.texel_x[1:0]);
    code = c[32 + 2 * s +: 2];
    four = (c[15:0] > c[31:16]) || r.format[1];
    for (int k = 0; k < 3; k++) begin
      case (code)
        2'h0: q[k] = p0[k];
        2'h1: q[k] = p1[k];
        2'h2: q[k] = four ? 8'((2 * p0[k] + p1[k]) / 3) : 8'((int'(p0[k]) + p1[k]) / 2);
        default: q[k] = four ? 8'((p0[k] + 2 * p1[k]) / 3) : 8'h00;
      endcase
    end
    case (r.format)
      COLOUR_ONLY_BLOCK_FORMAT: a = 8'hFF;
      ONE_BIT_ALPHA_BLOCK_FORMAT: a = (!four && code == 2'h3) ? 8'h00 : 8'hFF;
      EXPLICIT_ALPHA_BLOCK_FORMAT: a = 8'(r.block[4 * s +: 4] * 17);
      default: a = (r.block[16 + 3 * s +: 3] == 3'h1) ? r.block[15:8] : r.block[7:0];
    endcase
    bs = r.format[1] ? 16 : 8;
    bx = (int'(r.width) + 3) / 4;
    return {q[0], q[1], q[2], a, 26'(bs * (bx * int'(r.texel_y / 4) + int'(r.texel_x / 4))),
            26'(bs * bx * ((int'(r.height) + 3) / 4)), (r.texel_x >= r.width) || (r.texel_y >= r.height)};
  endfunction

  // ****************************************************************
  // Shared driving and checking tasks
  // ****************************************************************
  task automatic tick();
    @(posedge clock_i);
    #2;
  endtask

  task automatic send(input btd_request_t r);
    req_valid_i = 1'b1;
    req_i = r;
    exp_q.push_back(expect_ans(r));
  endtask

  // Answers must match the expectations one for one and in order
  task automatic compare_all();
    logic [84:0] got;
    logic [84:0] exp;
    `CHK(u_btd_sampler_model.answer_q.size(), exp_q.size())
    while (exp_q.size() > 0 && u_btd_sampler_model.answer_q.size() > 0) begin
      got = u_btd_sampler_model.answer_q.pop_front();
      exp = exp_q.pop_front();
      // Texel contents outside a small image carry no meaning
      if (exp[0]) begin
        got[84:53] = exp[84:53];
      end
      `CHK(got, exp)
    end
    exp_q.delete();
    u_btd_sampler_model.answer_q.delete();
  endtask

  // One request; strobe must appear exactly two edges later for one cycle
  task automatic t_single(input btd_request_t r);
    send(r);
    tick();
    req_valid_i = 1'b0;
    `CHK(texel_valid_o, 1'b0)
    tick();
    `CHK(texel_valid_o, 1'b1)
    tick();
    `CHK(texel_valid_o, 1'b0)
    compare_all();
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  // Every format, both endpoint orders, all sixteen slots; small images give outside texels
  task automatic t_formats();
    btd_request_t r;
    logic [63:0]  c;
    for (int f = 0; f < 4; f++) begin
      for (int m = 0; m < 2; m++) begin
        for (int s = 0; s < 16; s++) begin
          c = m ? C_LE : C_GT;
          r.format = btd_format_t'(2'(f));
          r.block = (f >= 2) ? {c, (f == 2) ? A_EXP : A_INT} : {~c, c};
          r.texel_x = 12'(s % 4 + 4 * (s % 3));
          r.texel_y = 12'(s / 4 + 4 * (s % 2));
          r.width = m ? 12'h003 : 12'h00D;
          r.height = m ? 12'h002 : 12'h009;
          t_single(r);
        end
      end
    end
  endtask

  // Valid held for four cycles: four answers back to back, in order
  task automatic t_back2back();
    btd_request_t r;
    for (int i = 0; i < 4; i++) begin
      r = '{INTERPOLATED_ALPHA_BLOCK_FORMAT, {C_GT, A_INT}, 12'(i + 4), 12'(i), 12'h010, 12'h010};
      r.width = 12'hFFF;
      r.height = 12'hFFF;
      send(r);
      tick();
    end
    req_valid_i = 1'b0;
    `CHK(texel_valid_o, 1'b1)
    repeat (3) tick();
    compare_all();
  endtask

  // A request lost to a reset in flight leaves every output cleared
  task automatic t_reset_mid();
    send('{EXPLICIT_ALPHA_BLOCK_FORMAT, {C_GT, A_EXP}, 12'h005, 12'h006, 12'h020, 12'h020});
    tick();
    req_valid_i = 1'b0;
    reset_n_i = 1'b0;
    tick();
    reset_n_i = 1'b1;
    `CHK({texel_valid_o, texel_o, block_offset_o, image_bytes_o, texel_outside_o}, 86'h0)
    repeat (2) tick();
    exp_q.delete();
    compare_all();
  endtask

  task automatic test_done();
    if (err_total == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Reset, then the scenarios in turn
  initial begin
    clock_i = 1'b0;
    reset_n_i = 1'b0;
    req_valid_i = 1'b0;
    req_i = '0;
    err_total = 0;
    cmp_count = 0;
    cyc_count = 0;
    repeat (2) @(posedge clock_i);
    #2;
    reset_n_i = 1'b1;
    `CHK({texel_valid_o, texel_o, block_offset_o, image_bytes_o, texel_outside_o}, 86'h0)
    t_formats();
    t_back2back();
    t_reset_mid();
    test_done();
  end
endmodule

`default_nettype wire

/* File: hw/btd_colour_unit.sv */
// Colour half decoder: endpoints, colour code and interpolation
`default_nettype none

module btd_colour_unit
  import btd_pkg::*;
(
  // Colour half of the block and texel position
  input  wire logic [63:0] colour_block_i,
  input  wire logic [3:0]  slot_i,
  input  wire logic        four_colour_i,
  // Decoded colour
  output var  btd_rgb_t    rgb_o,
  output var  logic        transparent_o
);

  logic [15:0] first_endpoint_colour;
  logic [15:0] second_endpoint_colour;
  btd_rgb_t    first_endpoint_rgb;
  btd_rgb_t    second_endpoint_rgb;
  logic [1:0]  code;
  logic        four_mode;
  logic [8:0]  sum_r;
  logic [8:0]  sum_g;
  logic [8:0]  sum_b;

  // ****************************************************************
  // Endpoint unpacking and palette pick
  // ****************************************************************
  always_comb begin
    first_endpoint_colour  = colour_block_i[FIRST_ENDPOINT_LSB +: 16];
    second_endpoint_colour = colour_block_i[SECOND_ENDPOINT_LSB +: 16];
    first_endpoint_rgb     = unpack_565(first_endpoint_colour);
    second_endpoint_rgb    = unpack_565(second_endpoint_colour);
    code                   = colour_code(colour_block_i, slot_i);
    // Large formats force the four-colour palette
    four_mode = four_colour_i || (first_endpoint_colour > second_endpoint_colour);
    sum_r = {1'b0, first_endpoint_rgb.red} + {1'b0, second_endpoint_rgb.red};
    sum_g = {1'b0, first_endpoint_rgb.green} + {1'b0, second_endpoint_rgb.green};
    sum_b = {1'b0, first_endpoint_rgb.blue} + {1'b0, second_endpoint_rgb.blue};
    case (code)
      2'h0: rgb_o = first_endpoint_rgb;
      2'h1: rgb_o = second_endpoint_rgb;
      2'h2: begin
        if (four_mode) begin
          rgb_o.red   = third_mix(first_endpoint_rgb.red, second_endpoint_rgb.red);
          rgb_o.green = third_mix(first_endpoint_rgb.green, second_endpoint_rgb.green);
          rgb_o.blue  = third_mix(first_endpoint_rgb.blue, second_endpoint_rgb.blue);
        end else begin
          rgb_o.red   = sum_r[8:1];
          rgb_o.green = sum_g[8:1];
          rgb_o.blue  = sum_b[8:1];
        end
      end
      default: begin
        if (four_mode) begin
          rgb_o.red   = third_mix(second_endpoint_rgb.red, first_endpoint_rgb.red);
          rgb_o.green = third_mix(second_endpoint_rgb.green, first_endpoint_rgb.green);
          rgb_o.blue  = third_mix(second_endpoint_rgb.blue, first_endpoint_rgb.blue);
        end else begin
          rgb_o = '0;
        end
      end
    endcase
    transparent_o = !four_mode && (code == 2'h3);
  end

endmodule

`default_nettype wire

/* File: hw/btd_decoder.sv */
// Block texture decoder top: address, colour and alpha decode in two stages
//
// Functional notes
// - Blocks are 4x4 texels of 64 or 128 bits
// - Image bytes: blocks across times down times size
// - Block offset from block row and column
// - Texels beyond a small image are don't-care
// - Endpoints and index word little-endian in address order
// - Endpoints unpack as 5-6-5 red, green, blue
// - Colour code from bits 2*(4y+x)+1..2*(4y+x)
// - First endpoint greater: four-colour thirds palette
// - Otherwise average for code 2, black for 3
// - Colour-only format always fully opaque
// - One-bit alpha zero only for transparent code
// - Explicit alpha: colour half always four-colour
// - Explicit alpha nibble at bits 4*(4y+x)+3..
// - Explicit alpha scaled as nibble over fifteen
// - Interpolated alpha: colour half always four-colour
// - Alpha endpoints are the first two bytes
// - Three-bit alpha codes from 48-bit index word
// - Alpha codes 0 and 1 pick the endpoints
`default_nettype none

module btd_decoder
  import btd_pkg::*;
(
  // Clock and reset
  input  wire logic                clock_i,
  input  wire logic                reset_n_i,
  // Request from texture fetch
  input  wire logic                req_valid_i,
  input  wire btd_request_t        req_i,
  // Answer to the sampler
  output logic                     texel_valid_o,
  output btd_texel_t               texel_o,
  output logic [OFFSET_W-1:0]      block_offset_o,
  output logic [OFFSET_W-1:0]      image_bytes_o,
  output logic                     texel_outside_o
);

  btd_state_t                 state;
  btd_state_t                 next_state;
  logic                       large_block;
  logic                       four_colour;
  logic [63:0]                colour_half;
  logic [63:0]                alpha_half;
  logic [3:0]                 slot;
  btd_rgb_t                   decoded_rgb;
  logic                       transparent;
  logic [3:0]                 alpha_nibble;
  logic [2:0]                 alpha_code;
  logic [7:0]                 first_alpha_endpoint;
  logic [7:0]                 second_alpha_endpoint;
  logic [47:0]                alpha_index_word;
  logic [7:0]                 alpha;
  logic [BLOCK_COUNT_W-1:0]   blocks_wide;
  logic [BLOCK_COUNT_W-1:0]   blocks_high;
  logic [OFFSET_W-1:0]        block_index;
  logic [OFFSET_W-1:0]        offset;
  logic [OFFSET_W-1:0]        image_bytes;

  // ****************************************************************
  // Block halves
  // ****************************************************************
  // Small formats hold only colour; large ones put alpha first
  always_comb begin
    large_block = state.s1_req.format[1];
    four_colour = large_block;
    colour_half = large_block ? state.s1_req.block[COLOUR_HALF_LSB +: 64]
                              : state.s1_req.block[63:0];
    alpha_half  = state.s1_req.block[63:0];
    slot        = texel_slot(state.s1_req.texel_x[1:0], state.s1_req.texel_y[1:0]);
  end

  // Colour decode of the selected half
  btd_colour_unit u_colour (
    .colour_block_i (colour_half),
    .slot_i         (slot),
    .four_colour_i  (four_colour),
    .rgb_o          (decoded_rgb),
    .transparent_o  (transparent)
  );

  // ****************************************************************
  // Alpha decode
  // ****************************************************************
  always_comb begin
    alpha_nibble          = alpha_half[4 * int'(slot) +: 4];
    first_alpha_endpoint  = alpha_half[FIRST_ALPHA_LSB +: 8];
    second_alpha_endpoint = alpha_half[SECOND_ALPHA_LSB +: 8];
    alpha_index_word      = alpha_half[ALPHA_INDEX_LSB +: 48];
    alpha_code            = alpha_index_word[3 * int'(slot) +: 3];
    case (state.s1_req.format)
      COLOUR_ONLY_BLOCK_FORMAT: begin
        alpha = OPAQUE_ALPHA;
      end
      ONE_BIT_ALPHA_BLOCK_FORMAT: begin
        alpha = transparent ? TRANSPARENT_ALPHA : OPAQUE_ALPHA;
      end
      EXPLICIT_ALPHA_BLOCK_FORMAT: begin
        alpha = 8'({4'h0, alpha_nibble} * EXPLICIT_ALPHA_SCALE);
      end
      INTERPOLATED_ALPHA_BLOCK_FORMAT: begin
        case (alpha_code)
          3'h1:    alpha = second_alpha_endpoint;
          // Codes above 1 fall back to the first endpoint
          default: alpha = first_alpha_endpoint;
        endcase
      end
      default: begin
        alpha = OPAQUE_ALPHA;
      end
    endcase
  end

  // ****************************************************************
  // Block addressing
  // ****************************************************************
  // Block row times blocks per row plus block column, scaled by size
  always_comb begin
    blocks_wide = blocks_across(state.s1_req.width);
    blocks_high = blocks_across(state.s1_req.height);
    block_index = OFFSET_W'(blocks_wide) * OFFSET_W'(state.s1_req.texel_y[COORD_W-1:2])
                + OFFSET_W'(state.s1_req.texel_x[COORD_W-1:2]);
    offset      = block_index * OFFSET_W'(block_bytes(state.s1_req.format));
    image_bytes = OFFSET_W'(blocks_wide) * OFFSET_W'(blocks_high)
                * OFFSET_W'(block_bytes(state.s1_req.format));
  end

  // ****************************************************************
  // Pipeline next state
  // ****************************************************************
  // Stage one captures the request, stage two holds the answer
  always_comb begin
    next_state          = state;
    next_state.s1_valid = req_valid_i;
    if (req_valid_i) begin
      next_state.s1_req = req_i;
    end
    next_state.out_valid = state.s1_valid;
    if (state.s1_valid) begin
      next_state.out_texel.rgb   = decoded_rgb;
      next_state.out_texel.alpha = alpha;
      next_state.out_offset      = offset;
      next_state.out_image_bytes = image_bytes;
      // Flag only; the texel itself is still decoded as stored
      next_state.out_outside     = (state.s1_req.texel_x >= state.s1_req.width)
                                || (state.s1_req.texel_y >= state.s1_req.height);
    end
  end

  // State register with synchronous clear
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  // Outputs straight from flip-flops
  assign texel_valid_o   = state.out_valid;
  assign texel_o         = state.out_texel;
  assign block_offset_o  = state.out_offset;
  assign image_bytes_o   = state.out_image_bytes;
  assign texel_outside_o = state.out_outside;

  // ****************************************************************
  // Checks
  // ****************************************************************
  logic [15:0]         chk_e0;
  logic [15:0]         chk_e1;
  logic [63:0]         chk_colour;
  logic [1:0]          chk_code;
  logic [3:0]          chk_slot;
  logic [7:0]          chk_r0;
  logic [7:0]          chk_r1;
  logic [7:0]          chk_b0;
  logic [7:0]          chk_b1;
  logic [OFFSET_W-1:0] chk_offset;

  // Reference values worked straight from the incoming request
  always_comb begin
    chk_colour = req_i.format[1] ? req_i.block[127:64] : req_i.block[63:0];
    chk_e0     = chk_colour[15:0];
    chk_e1     = chk_colour[31:16];
    chk_slot   = {req_i.texel_y[1:0], req_i.texel_x[1:0]};
    chk_code   = chk_colour[32 + 2 * int'(chk_slot) +: 2];
    chk_r0     = {chk_e0[15:11], chk_e0[15:13]};
    chk_r1     = {chk_e1[15:11], chk_e1[15:13]};
    chk_b0     = {chk_e0[4:0], chk_e0[4:2]};
    chk_b1     = {chk_e1[4:0], chk_e1[4:2]};
    chk_offset = OFFSET_W'(block_bytes(req_i.format))
               * ((OFFSET_W'(req_i.width) + 26'h0000003) / 26'h0000004 * OFFSET_W'(req_i.texel_y[COORD_W-1:2])
               + OFFSET_W'(req_i.texel_x[COORD_W-1:2]));
  end

  property p_fixed_latency;
    @(posedge clock_i) disable iff (!reset_n_i)
    req_valid_i |-> ##2 texel_valid_o;
  endproperty
  a_fixed_latency: assert property (p_fixed_latency) else $error("answer not two cycles after request");

  // No answer strobe without a request two edges before
  property p_no_spurious_answer;
    @(posedge clock_i) disable iff (!reset_n_i)
    !req_valid_i |-> ##2 !texel_valid_o;
  endproperty
  a_no_spurious_answer: assert property (p_no_spurious_answer) else $error("answer without request");

  property p_block_offset;
    @(posedge clock_i) disable iff (!reset_n_i)
    req_valid_i |-> ##2 block_offset_o == $past(chk_offset, 2);
  endproperty
  a_block_offset: assert property (p_block_offset) else $error("block byte offset wrong");

  property p_endpoint_red;
    @(posedge clock_i) disable iff (!reset_n_i)
    req_valid_i && chk_code == 2'h0 |-> ##2 texel_o.rgb.red == $past(chk_r0, 2);
  endproperty
  a_endpoint_red: assert property (p_endpoint_red) else $error("code 0 red differs from first endpoint");

  property p_four_colour_third;
    @(posedge clock_i) disable iff (!reset_n_i)
    req_valid_i && chk_e0 > chk_e1 && chk_code == 2'h2
      |-> ##2 texel_o.rgb.red == $past(third_mix(chk_r0, chk_r1), 2);
  endproperty
  a_four_colour_third: assert property (p_four_colour_third) else $error("code 2 red is not two thirds mix");

  property p_black_code;
    @(posedge clock_i) disable iff (!reset_n_i)
    req_valid_i && !req_i.format[1] && chk_e0 <= chk_e1 && chk_code == 2'h3
      |-> ##2 texel_o.rgb == '0;
  endproperty
  a_black_code: assert property (p_black_code) else $error("three-colour code 3 not black");

  property p_colour_only_opaque;
    @(posedge clock_i) disable iff (!reset_n_i)
    req_valid_i && req_i.format == COLOUR_ONLY_BLOCK_FORMAT |-> ##2 texel_o.alpha == OPAQUE_ALPHA;
  endproperty
  a_colour_only_opaque: assert property (p_colour_only_opaque) else $error("colour-only texel not opaque");

  property p_one_bit_alpha;
    @(posedge clock_i) disable iff (!reset_n_i)
    req_valid_i && req_i.format == ONE_BIT_ALPHA_BLOCK_FORMAT
      |-> ##2 (texel_o.alpha == TRANSPARENT_ALPHA) == $past(chk_e0 <= chk_e1 && chk_code == 2'h3, 2);
  endproperty
  a_one_bit_alpha: assert property (p_one_bit_alpha) else $error("one-bit alpha wrong");

  property p_forced_four_colour;
    @(posedge clock_i) disable iff (!reset_n_i)
    req_valid_i && req_i.format[1] && chk_e0 <= chk_e1 && chk_code == 2'h3
      |-> ##2 texel_o.rgb.blue == $past(third_mix(chk_b1, chk_b0), 2);
  endproperty
  a_forced_four_colour: assert property (p_forced_four_colour) else $error("large block not four-colour");

  property p_explicit_alpha;
    @(posedge clock_i) disable iff (!reset_n_i)
    req_valid_i && req_i.format == EXPLICIT_ALPHA_BLOCK_FORMAT
      |-> ##2 texel_o.alpha == $past({2{req_i.block[4 * int'(chk_slot) +: 4]}}, 2);
  endproperty
  a_explicit_alpha: assert property (p_explicit_alpha) else $error("explicit alpha not nibble over fifteen");

  property p_alpha_endpoint;
    @(posedge clock_i) disable iff (!reset_n_i)
    req_valid_i && req_i.format == INTERPOLATED_ALPHA_BLOCK_FORMAT
      && req_i.block[16 + 3 * int'(chk_slot) +: 3] == 3'h1
      |-> ##2 texel_o.alpha == $past(req_i.block[15:8], 2);
  endproperty
  a_alpha_endpoint: assert property (p_alpha_endpoint) else $error("alpha code 1 not second endpoint");

endmodule

`default_nettype wire

/* File: hw/btd_pkg.sv */
// Shared types, constants and helpers for the block texture decoder
`default_nettype none

package btd_pkg;

  // ****************************************************************
  // Block formats
  // ****************************************************************
  typedef enum logic [1:0] {
    COLOUR_ONLY_BLOCK_FORMAT        = 2'b00,
    ONE_BIT_ALPHA_BLOCK_FORMAT      = 2'b01,
    EXPLICIT_ALPHA_BLOCK_FORMAT     = 2'b10,
    INTERPOLATED_ALPHA_BLOCK_FORMAT = 2'b11
  } btd_format_t;

  // ****************************************************************
  // Widths, field positions and fixed values
  // ****************************************************************
  localparam int COORD_W             = 12;   // Image width, height and texel coordinates
  localparam int BLOCK_COUNT_W       = 11;   // Blocks across or down an image
  localparam int OFFSET_W            = 26;   // Byte offsets and image sizes
  localparam logic [4:0] SMALL_BLOCK_BYTES = 5'h08;
  localparam logic [4:0] LARGE_BLOCK_BYTES = 5'h10;
  localparam int COLOUR_HALF_LSB     = 64;   // Colour half inside a large block
  localparam int FIRST_ENDPOINT_LSB  = 0;
  localparam int SECOND_ENDPOINT_LSB = 16;
  localparam int COLOUR_INDEX_LSB    = 32;
  localparam int RED_LSB             = 11;
  localparam int GREEN_LSB           = 5;
  localparam int BLUE_LSB            = 0;
  localparam int FIRST_ALPHA_LSB     = 0;
  localparam int SECOND_ALPHA_LSB    = 8;
  localparam int ALPHA_INDEX_LSB     = 16;
  localparam logic [7:0] OPAQUE_ALPHA         = 8'hFF;
  localparam logic [7:0] TRANSPARENT_ALPHA    = 8'h00;
  localparam logic [7:0] EXPLICIT_ALPHA_SCALE = 8'h11;  // 255 / 15
  localparam logic [1:0] BLOCK_ROUND          = 2'h3;   // Added before dividing by four

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    logic [7:0] red;
    logic [7:0] green;
    logic [7:0] blue;
  } btd_rgb_t;

  typedef struct packed {
    btd_rgb_t   rgb;
    logic [7:0] alpha;
  } btd_texel_t;

  typedef struct packed {
    btd_format_t          format;
    logic [127:0]         block;    // Byte n of the block at bits 8n+7..8n
    logic [COORD_W-1:0]   texel_x;
    logic [COORD_W-1:0]   texel_y;
    logic [COORD_W-1:0]   width;
    logic [COORD_W-1:0]   height;
  } btd_request_t;

  typedef struct packed {
    logic                 s1_valid;
    btd_request_t         s1_req;
    logic                 out_valid;
    btd_texel_t           out_texel;
    logic [OFFSET_W-1:0]  out_offset;
    logic [OFFSET_W-1:0]  out_image_bytes;
    logic                 out_outside;
  } btd_state_t;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // Position of a texel inside its block, 4*y+x
  function automatic logic [3:0] texel_slot(input logic [1:0] x, input logic [1:0] y);
    return {y, x};
  endfunction

  // Two-bit colour code of a texel
  function automatic logic [1:0] colour_code(input logic [63:0] half, input logic [3:0] slot);
    return half[COLOUR_INDEX_LSB + 2 * int'(slot) +: 2];
  endfunction

  // Packed 5-6-5 endpoint widened to eight bits per component
  function automatic btd_rgb_t unpack_565(input logic [15:0] pix);
    btd_rgb_t c;
    c.red   = {pix[RED_LSB +: 5], pix[RED_LSB + 2 +: 3]};
    c.green = {pix[GREEN_LSB +: 6], pix[GREEN_LSB + 4 +: 2]};
    c.blue  = {pix[BLUE_LSB +: 5], pix[BLUE_LSB + 2 +: 3]};
    return c;
  endfunction

  // (2a+b)/3 on one component
  function automatic logic [7:0] third_mix(input logic [7:0] a, input logic [7:0] b);
    logic [9:0] s;
    s = {1'b0, a, 1'b0} + {2'h0, b};
    return 8'(s / 10'h003);
  endfunction

  // Blocks needed to cover one image dimension
  function automatic logic [BLOCK_COUNT_W-1:0] blocks_across(input logic [COORD_W-1:0] dim);
    logic [COORD_W:0] s;
    s = {1'b0, dim} + {11'h000, BLOCK_ROUND};
    return s[COORD_W:2];
  endfunction

  // Bytes in one block of a format
  function automatic logic [4:0] block_bytes(input btd_format_t fmt);
    return fmt[1] ? LARGE_BLOCK_BYTES : SMALL_BLOCK_BYTES;
  endfunction

endpackage

`default_nettype wire
